// *** core/fsc_pkg.sv ***
// Purpose: shared constants and types for the flash status-2 / config-1 register bank
// Assumes: serial command link in clock mode 0, 24-bit register addresses
// Notes:   register addresses are local to this bank
package fsc_pkg;

  // command opcodes
  localparam logic [7:0] CMD_WRITE_REGISTERS = 8'h01;
  localparam logic [7:0] CMD_READ_STATUS_TWO = 8'h07;
  localparam logic [7:0] CMD_READ_ANY        = 8'h65;
  localparam logic [7:0] CMD_WRITE_ANY       = 8'h71;

  // register addresses for the any-register commands
  localparam logic [23:0] ADDR_NONVOLATILE_STATUS_ONE = 24'h000000;
  localparam logic [23:0] ADDR_NONVOLATILE_PROTECTION_CONFIG = 24'h000002;
  localparam logic [23:0] ADDR_VOLATILE_STATUS_ONE  = 24'h800000;
  localparam logic [23:0] ADDR_SUSPEND_AND_ERASE_OUTCOME_STATUS  = 24'h800001;
  localparam logic [23:0] ADDR_VOLATILE_PROTECTION_CONFIG  = 24'h800002;

  // field positions
  localparam int SR2_OUTCOME  = 2;
  localparam int SR2_ERS_SUSP = 1;
  localparam int SR2_PGM_SUSP = 0;
  localparam int CR1_ORIGIN   = 5;
  localparam int CR1_VOLSEL   = 3;
  localparam int CR1_PARAM    = 2;
  localparam int CR1_QUAD     = 1;
  localparam int CR1_FREEZE   = 0;
  localparam int SR1_BP_LO    = 2;
  localparam int SR1_BP_HI    = 4;

  // reset and shipped values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] BP_SHIP   = 3'h0;
  localparam logic [2:0] BP_ALL    = 3'h7;
  localparam logic [2:0] BP_TOP    = 3'h7;

  // framing
  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [1:0] WRR_FULL  = 2'h2;
  localparam logic [1:0] ONE_BYTE  = 2'h1;

  // timing
  localparam int CLK_MHZ = 10;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } fsc_pins_t;

  typedef struct packed {
    logic erase_outcome;
    logic erase_outcome_load;
    logic erase_suspended;
    logic program_suspended;
  } fsc_core_status_t;

  typedef struct packed {
    logic [2:0] protect_range_bits;
    logic       protection_origin;
    logic       parameter_top;
    logic       quad_width;
    logic       freeze;
    logic       bulk_erase_ok;
  } fsc_prot_t;

  typedef enum logic [2:0] {
    ST_CMD  = 3'b000,
    ST_ADDR = 3'b001,
    ST_DIN  = 3'b010,
    ST_DOUT = 3'b011,
    ST_IGN  = 3'b100
  } fsc_state_t;

  typedef enum logic [2:0] {
    SEL_NONE  = 3'b000,
    SEL_NONVOLATILE_STATUS_ONE = 3'b001,
    SEL_NONVOLATILE_PROTECTION_CONFIG = 3'b010,
    SEL_VOLATILE_STATUS_ONE  = 3'b011,
    SEL_SUSPEND_AND_ERASE_OUTCOME_STATUS  = 3'b100,
    SEL_VOLATILE_PROTECTION_CONFIG  = 3'b101
  } fsc_sel_t;

endpackage

// *** core/fsc_sync.sv ***
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module fsc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_dout;

  // hold both stages while the clock enable is low
  always_comb begin
    next_meta = ce ? din : meta;
    next_dout = ce ? meta : dout;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end
endmodule // fsc_sync

// *** core/fsc_regs.sv ***
// Purpose: status register 2 and config register 1 bank behind the serial command link
// Assumes: link clock mode 0, sampled by clk_sys at well over twice its rate
// Notes:   nonvolatile cells are modelled as flops reset to shipped values
// Overview of operation
// - status 2 is read-only via 07h and 65h; bits set by hardware only.
// - bit 2 reports last erase outcome of sector from erase-status command; resets 0.
// - erase outcome only valid right after erase-status; not during suspend.
// - bit 1 shows erase suspend; user writes ignored.
// - bit 0 shows program suspend; user writes ignored.
// - config 1 written by 01h with sixteen data bits or by 71h.
// - config bit 5 picks protection origin; one-time programmable, ships 0.
// - programmed one-time bits stay 1 on a zero write, no program error.
// - bit 3 at 0 means nonvolatile protect bits govern, written slowly by 01h.
// - setting bit 3 programs nonvolatile protect bits to 111, reloaded on command reset.
// - volatile selection makes 01h write only volatile protect bits, quickly.
// - config bit 2 places parameter sectors top or bottom; one-time, ships 0.
// - with uniform sectors the placement bit has no effect.
// - origin and placement bits are set independently.
// - config bit 1 is reset default of quad bit; both writes change it.
// - programming nonvolatile QPI enable also programs quad default to 1.
// - while volatile QPI is on, clearing quad default is refused.
// - config bit 0 is read-only freeze default.
// - config bits 7, 6 and 4 are reserved and read 0.
// - nonzero protect bits guard a sector range; bulk erase only with all zero.
// - freeze set makes protect bit writes silently ignored.
`timescale 1ns/100ps
module fsc_regs
  import fsc_pkg::*;
#(
  parameter int         SECTOR_BITS  = 8,
  parameter int         NV_WRITE_US  = 500,
  parameter int         VOL_WRITE_NS = 100,
  parameter logic       FREEZE_D     = 1'b0,
  parameter logic [23:0] NV_CYCLES   = 24'(NV_WRITE_US * CLK_MHZ)
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire fsc_pins_t              pins,
  output logic                        so_out,
  output logic                        so_oe,
  input  wire logic                   soft_reset,
  input  wire fsc_core_status_t       core,
  input  wire logic                   qpi_volatile,
  input  wire logic                   qpi_nv_program,
  input  wire logic                   uniform_sectors,
  input  wire logic [SECTOR_BITS-1:0] sector,
  output logic                        sector_protected,
  output fsc_prot_t                   prot,
  output logic                        write_busy
);
  localparam int          VOL_RAW    = (VOL_WRITE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [23:0] VOL_CYCLES = 24'((VOL_RAW < 1) ? 1 : VOL_RAW);

  // pin sampling; link clock is just another asynchronous level here
  fsc_pins_t pins_s;
  fsc_sync #(.W(3)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .din     (pins),
    .dout    (pins_s)
  );

  fsc_state_t  state, next_state;
  logic        sck_d, next_sck_d, cs_d, next_cs_d;
  logic [2:0]  bit_cnt, next_bit_cnt;
  logic [1:0]  byte_cnt, next_byte_cnt;
  logic [7:0]  shin, next_shin, shout, next_shout, cmd, next_cmd;
  logic [7:0]  wr0, next_wr0, wr1, next_wr1;
  logic [23:0] addr, next_addr;
  logic        next_so_out, next_so_oe;
  logic [7:0]  byte_in;
  logic        rise, fall, commit;

  logic [2:0]  nonvolatile_protect_bits, next_nonvolatile_protect_bits, bp_v, next_bp_v;
  logic        origin, next_origin, volsel, next_volsel, param, next_param;
  logic        quad_width_default, next_quad_width_default, quad_v, next_quad_v;
  logic        freeze, next_freeze, outcome, next_outcome;
  logic [23:0] busy_cnt, next_busy_cnt;
  fsc_prot_t   next_prot;
  logic        next_sector_protected;
  logic [7:0]  sr2_byte, nonvolatile_protection_config_byte, volatile_protection_config_byte, sr1_byte;
  logic        commit_wrr, commit_write_any_register_cmd, wr_sr1, wr_nonvolatile_protection_config, wr_volatile_protection_config;
  logic        busy, suspended;
  logic [7:0]  cr1_data;
  logic [2:0]  bp_act;
  fsc_sel_t    sel_cur;

  // address decode, used for both reads and writes
  function automatic fsc_sel_t sel_of(input logic [23:0] a);
    unique case (a)
      ADDR_NONVOLATILE_STATUS_ONE: sel_of = SEL_NONVOLATILE_STATUS_ONE;
      ADDR_NONVOLATILE_PROTECTION_CONFIG: sel_of = SEL_NONVOLATILE_PROTECTION_CONFIG;
      ADDR_VOLATILE_STATUS_ONE:  sel_of = SEL_VOLATILE_STATUS_ONE;
      ADDR_SUSPEND_AND_ERASE_OUTCOME_STATUS:  sel_of = SEL_SUSPEND_AND_ERASE_OUTCOME_STATUS;
      ADDR_VOLATILE_PROTECTION_CONFIG:  sel_of = SEL_VOLATILE_PROTECTION_CONFIG;
      default:    sel_of = SEL_NONE;
    endcase
  endfunction

  // sector guard: range doubles per protect code, grows from the chosen end
  function automatic logic in_range(input logic [SECTOR_BITS-1:0] s,
                                    input logic [2:0] bp, input logic from_bottom);
    logic [SECTOR_BITS:0] total;
    logic [SECTOR_BITS:0] cnt;
    total = {1'b1, {SECTOR_BITS{1'b0}}};
    cnt   = total >> (BP_TOP - bp);
    if (bp == BP_SHIP)
      in_range = 1'b0;
    else if (from_bottom)
      in_range = ({1'b0, s} < cnt);
    else
      in_range = ({1'b0, s} >= (total - cnt));
  endfunction

  // register images as read out; reserved bits read zero
  always_comb begin
    sr2_byte = BYTE_ZERO;
    sr2_byte[SR2_OUTCOME]  = outcome;
    sr2_byte[SR2_ERS_SUSP] = core.erase_suspended;
    sr2_byte[SR2_PGM_SUSP] = core.program_suspended;
    nonvolatile_protection_config_byte = BYTE_ZERO;
    nonvolatile_protection_config_byte[CR1_ORIGIN] = origin;
    nonvolatile_protection_config_byte[CR1_VOLSEL] = volsel;
    nonvolatile_protection_config_byte[CR1_PARAM]  = param;
    nonvolatile_protection_config_byte[CR1_QUAD]   = quad_width_default;
    nonvolatile_protection_config_byte[CR1_FREEZE] = FREEZE_D;
    volatile_protection_config_byte = nonvolatile_protection_config_byte;
    volatile_protection_config_byte[CR1_QUAD]   = quad_v;
    volatile_protection_config_byte[CR1_FREEZE] = freeze;
    sr1_byte = BYTE_ZERO;
    sr1_byte[SR1_BP_HI:SR1_BP_LO] = (sel_cur == SEL_NONVOLATILE_STATUS_ONE) ? nonvolatile_protect_bits : bp_v;
  end

  assign sel_cur = sel_of(addr);
  assign rise    = ce & ~pins_s.cs_n & pins_s.sck & ~sck_d;
  assign fall    = ce & ~pins_s.cs_n & ~pins_s.sck & sck_d;
  assign commit  = ce & pins_s.cs_n & ~cs_d & (state == ST_DIN) & (bit_cnt == '0)
                   & (byte_cnt != '0) & ~busy;
  assign byte_in = {shin[6:0], pins_s.si};

  // command framing: shift in on rising edge, drive out on falling edge
  always_comb begin
    next_state = state; next_bit_cnt = bit_cnt; next_byte_cnt = byte_cnt;
    next_shin = shin; next_shout = shout; next_cmd = cmd; next_addr = addr;
    next_wr0 = wr0; next_wr1 = wr1; next_so_out = so_out; next_so_oe = so_oe;
    next_sck_d = ce ? pins_s.sck : sck_d;
    next_cs_d  = ce ? pins_s.cs_n : cs_d;
    if (ce & pins_s.cs_n) begin
      next_state = ST_CMD; next_bit_cnt = '0; next_so_oe = 1'b0;
    end else if (rise) begin
      next_shin    = byte_in;
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == LAST_BIT) begin
        unique case (state)
          ST_CMD: begin
            next_cmd = byte_in; next_byte_cnt = '0;
            if (byte_in == CMD_READ_STATUS_TWO) begin
              next_state = ST_DOUT; next_shout = sr2_byte;
            end else if (byte_in == CMD_READ_ANY || byte_in == CMD_WRITE_ANY)
              next_state = ST_ADDR;
            else if (byte_in == CMD_WRITE_REGISTERS)
              next_state = ST_DIN;
            else
              next_state = ST_IGN;
          end
          ST_ADDR: begin
            next_addr = {addr[15:0], byte_in};
            next_byte_cnt = byte_cnt + 2'h1;
            if (byte_cnt == ADDR_LAST) begin
              next_byte_cnt = '0;
              next_state = (cmd == CMD_READ_ANY) ? ST_DOUT : ST_DIN;
            end
          end
          ST_DIN: begin
            if (byte_cnt == '0) next_wr0 = byte_in;
            else if (byte_cnt == ONE_BYTE) next_wr1 = byte_in;
            if (byte_cnt != WRR_FULL) next_byte_cnt = byte_cnt + 2'h1;
          end
          ST_DOUT: next_shout = (cmd == CMD_READ_STATUS_TWO) ? sr2_byte : shout;
          ST_IGN:  next_state = ST_IGN;
        endcase
      end
    end else if (fall && state == ST_DOUT) begin
      next_so_out = shout[7];
      next_shout  = {shout[6:0], 1'b0};
      next_so_oe  = 1'b1;
    end
    // any-register read loads its image once the address is complete
    if (ce && state == ST_DOUT && cmd == CMD_READ_ANY && bit_cnt == '0 && !fall
        && sck_d && pins_s.sck && byte_cnt == '0 && !so_oe) begin
      unique case (sel_cur)
        SEL_NONVOLATILE_STATUS_ONE, SEL_VOLATILE_STATUS_ONE: next_shout = sr1_byte;
        SEL_NONVOLATILE_PROTECTION_CONFIG:           next_shout = nonvolatile_protection_config_byte;
        SEL_VOLATILE_PROTECTION_CONFIG:            next_shout = volatile_protection_config_byte;
        SEL_SUSPEND_AND_ERASE_OUTCOME_STATUS:            next_shout = sr2_byte;
        SEL_NONE:            next_shout = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_CMD; bit_cnt <= '0; byte_cnt <= '0; shin <= '0; shout <= '0;
      cmd <= '0; addr <= '0; wr0 <= '0; wr1 <= '0; so_out <= 1'b0; so_oe <= 1'b0;
      sck_d <= 1'b0; cs_d <= 1'b1;
    end else begin
      state <= next_state; bit_cnt <= next_bit_cnt; byte_cnt <= next_byte_cnt;
      shin <= next_shin; shout <= next_shout; cmd <= next_cmd; addr <= next_addr;
      wr0 <= next_wr0; wr1 <= next_wr1; so_out <= next_so_out; so_oe <= next_so_oe;
      sck_d <= next_sck_d; cs_d <= next_cs_d;
    end
  end

  // write decode; a status-2 address matches nothing and is dropped
  assign busy        = (busy_cnt != '0);
  assign suspended   = core.erase_suspended | core.program_suspended;
  assign commit_wrr  = commit & (cmd == CMD_WRITE_REGISTERS);
  assign commit_write_any_register_cmd = commit & (cmd == CMD_WRITE_ANY);
  assign wr_sr1      = commit_wrr | (commit_write_any_register_cmd & (sel_cur == SEL_NONVOLATILE_STATUS_ONE | sel_cur == SEL_VOLATILE_STATUS_ONE));
  assign wr_nonvolatile_protection_config    = (commit_wrr & (byte_cnt == WRR_FULL)) |
                       (commit_write_any_register_cmd & (sel_cur == SEL_NONVOLATILE_PROTECTION_CONFIG));
  assign wr_volatile_protection_config     = commit_write_any_register_cmd & (sel_cur == SEL_VOLATILE_PROTECTION_CONFIG);
  assign cr1_data    = commit_wrr ? wr1 : wr0;
  assign bp_act      = volsel ? bp_v : nonvolatile_protect_bits;
  assign write_busy  = busy;

  // register contents: next values
  always_comb begin
    next_nonvolatile_protect_bits = nonvolatile_protect_bits; next_bp_v = bp_v; next_origin = origin; next_volsel = volsel;
    next_param = param; next_quad_width_default = quad_width_default; next_quad_v = quad_v;
    next_freeze = freeze; next_outcome = outcome;
    next_busy_cnt = busy ? busy_cnt - 24'h1 : busy_cnt;
    if (ce && core.erase_outcome_load && !suspended)
      next_outcome = core.erase_outcome;
    if (ce && soft_reset) begin
      next_bp_v = nonvolatile_protect_bits;
      next_quad_v = quad_width_default;
      next_outcome = 1'b0;
    end
    if (wr_sr1 && !freeze) begin
      next_bp_v = wr0[SR1_BP_HI:SR1_BP_LO];
      if (volsel)
        next_busy_cnt = VOL_CYCLES;
      else begin
        next_nonvolatile_protect_bits = wr0[SR1_BP_HI:SR1_BP_LO];
        next_busy_cnt = NV_CYCLES;
      end
    end
    if (wr_nonvolatile_protection_config) begin
      if (!freeze) begin
        // one-time bits only ever go to 1; zeros are silently kept
        next_origin = origin | cr1_data[CR1_ORIGIN];
        next_param  = param | cr1_data[CR1_PARAM];
        next_volsel = volsel | cr1_data[CR1_VOLSEL];
        if (!volsel && cr1_data[CR1_VOLSEL])
          next_nonvolatile_protect_bits = BP_ALL;
      end
      next_quad_width_default  = cr1_data[CR1_QUAD] | (qpi_volatile & quad_width_default);
      next_quad_v   = next_quad_width_default;
      next_busy_cnt = NV_CYCLES;
    end
    if (wr_volatile_protection_config) begin
      next_quad_v = cr1_data[CR1_QUAD] | (qpi_volatile & quad_v);
      next_freeze = freeze | cr1_data[CR1_FREEZE];
      next_busy_cnt = VOL_CYCLES;
    end
    if (ce && qpi_nv_program)
      next_quad_width_default = 1'b1;
    next_prot.protect_range_bits = bp_act;
    next_prot.protection_origin  = origin;
    next_prot.parameter_top      = param & ~uniform_sectors;
    next_prot.quad_width         = quad_v;
    next_prot.freeze             = freeze;
    next_prot.bulk_erase_ok      = (bp_act == BP_SHIP);
    next_sector_protected        = in_range(sector, bp_act, origin);
    if (!ce) begin
      next_busy_cnt = busy_cnt; next_prot = prot;
      next_sector_protected = sector_protected;
    end
  end

  // power-on and hardware reset load shipped values; freeze from its default
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nonvolatile_protect_bits <= BP_SHIP; bp_v <= BP_SHIP; origin <= 1'b0; volsel <= 1'b0;
      param <= 1'b0; quad_width_default <= 1'b0; quad_v <= 1'b0; freeze <= FREEZE_D;
      outcome <= 1'b0; busy_cnt <= '0; prot <= '0; sector_protected <= 1'b0;
    end else begin
      nonvolatile_protect_bits <= next_nonvolatile_protect_bits; bp_v <= next_bp_v; origin <= next_origin;
      volsel <= next_volsel; param <= next_param; quad_width_default <= next_quad_width_default;
      quad_v <= next_quad_v; freeze <= next_freeze; outcome <= next_outcome;
      busy_cnt <= next_busy_cnt; prot <= next_prot;
      sector_protected <= next_sector_protected;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // a write that also sets volatile select fills the nv bits with 111 instead
  sequence s_nv_bp_write;
    wr_sr1 && !freeze && !volsel && !(wr_nonvolatile_protection_config && cr1_data[CR1_VOLSEL]);
  endsequence
  sequence s_vol_bp_write;
    wr_sr1 && !freeze && volsel && !wr_nonvolatile_protection_config;
  endsequence

  a_sr2_write_drop: assert property (commit_write_any_register_cmd && sel_cur == SEL_SUSPEND_AND_ERASE_OUTCOME_STATUS &&
    !core.erase_outcome_load |=> $stable(outcome))
    else $error("status 2 changed by a write");
  a_outcome_load: assert property (ce && core.erase_outcome_load && !suspended
    && !soft_reset |=> outcome == $past(core.erase_outcome))
    else $error("erase outcome not loaded");
  a_suspend_hold: assert property (suspended && !soft_reset |=> $stable(outcome))
    else $error("erase outcome moved during suspend");
  a_otp_sticky: assert property ((origin | param | volsel) |=> (origin >= $past(origin))
    && (param >= $past(param)) && (volsel >= $past(volsel)))
    else $error("one-time bit cleared");
  a_volsel_fill: assert property ($rose(volsel) |-> nonvolatile_protect_bits == BP_ALL)
    else $error("protect bits not set on volatile select");
  a_nv_write_slow: assert property (s_nv_bp_write |=> write_busy
    && nonvolatile_protect_bits == $past(wr0[SR1_BP_HI:SR1_BP_LO]) ##1 write_busy)
    else $error("nonvolatile protect write wrong");
  a_vol_write_nv: assert property (s_vol_bp_write |=> $stable(nonvolatile_protect_bits)
    && bp_v == $past(wr0[SR1_BP_HI:SR1_BP_LO]))
    else $error("volatile protect write touched nonvolatile bits");
  a_quad_refused: assert property (qpi_volatile && quad_width_default |=> quad_width_default)
    else $error("quad default cleared under qpi");
  a_freeze_lock: assert property (freeze && !(ce && soft_reset)
    |=> $stable(nonvolatile_protect_bits) && $stable(bp_v) && freeze)
    else $error("protect bits changed while frozen");
  a_bulk_gate: assert property (ce ##1 ce |-> prot.bulk_erase_ok
    == ($past(bp_act) == BP_SHIP))
    else $error("bulk erase gate wrong");
endmodule // fsc_regs

// *** tb/fsc_host_model.sv ***
// Purpose: host controller model driving the serial command link in clock mode 0
// Assumes: link clock of 800 ns made from 4 + 4 system clock cycles
// Notes:   data line shows the inverse of its last bit once the frame ends
`timescale 1ns/100ps
module fsc_host_model
  import fsc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic so_out,
  input  wire logic write_busy,
  output fsc_pins_t pins
);
  logic cs_n = 1'b1;
  logic sck  = 1'b0;
  logic si   = 1'b1;
  assign pins = {cs_n, sck, si};

  // one byte msb first; si moves only while sck is low
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      repeat (4) @(negedge clk_sys);
      sck = 1'b1;
      repeat (4) @(negedge clk_sys);
      rx[i] = so_out; // read bit settled well before this fall
      sck = 1'b0;
    end
  endtask

  // frame with no data bytes reads one byte back
  task automatic frame(input logic [7:0] cmd, input logic [23:0] addr, input int n_addr,
                       input logic [15:0] wd, input int n_wr, output logic [7:0] rd);
    logic [7:0] junk;
    int         n;
    n = 0;
    cs_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    xfer(cmd, junk);
    for (int i = 0; i < n_addr; i++) xfer(addr[23-8*i -: 8], junk);
    for (int i = 0; i < n_wr; i++) xfer(wd[15-8*i -: 8], junk);
    if (n_wr == 0) xfer(~cmd, rd);
    repeat (4) @(negedge clk_sys);
    cs_n = 1'b1;
    si = ~si;
    repeat (8) @(negedge clk_sys);
    // a write frame sent while the write timer runs would be dropped
    while (write_busy !== 1'b0 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
endmodule // fsc_host_model

// *** tb/fsc_regs_tb_top.sv ***
// Purpose: self-checking bench for the status-2 / config-1 register bank
// Assumes: nonvolatile write time shortened to 20 cycles
// Notes:   one-time bits are set early, so scenario order matters
`timescale 1ns/100ps
module fsc_regs_tb_top;
  import fsc_pkg::*;
  localparam logic [23:0] NV_SIM = 24'h000014;
  logic             clk_sys, rst, ce, soft_reset, qpi_volatile, qpi_nv_program;
  logic             uniform_sectors, so_out, so_oe, sector_protected, write_busy;
  logic [7:0]       sector, rd;
  logic [2:0]       n;
  fsc_pins_t        pins;
  fsc_core_status_t core;
  fsc_prot_t        prot;
  int               num_errors, n_checks, cycles, busy_len, seed;

  fsc_regs #(.NV_CYCLES(NV_SIM)) u_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .pins(pins),
    .so_out(so_out), .so_oe(so_oe), .soft_reset(soft_reset), .core(core),
    .qpi_volatile(qpi_volatile), .qpi_nv_program(qpi_nv_program),
    .uniform_sectors(uniform_sectors), .sector(sector), .sector_protected(sector_protected),
    .prot(prot), .write_busy(write_busy));
  fsc_host_model u_host (.clk_sys(clk_sys), .so_out(so_out), .write_busy(write_busy),
    .pins(pins));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // busy length and hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (write_busy === 1'b1) busy_len <= busy_len + 1;
    if (cycles == 60000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // expected prot image; bulk erase allowed only with no active bits
  function automatic logic [7:0] pk(logic [2:0] bp, logic org, logic top, logic q, logic f);
    return {bp, org, top, q, f, bp == 3'h0};
  endfunction

  // nonzero code n covers 256 >> (7 - n) sectors from the chosen end; code 0 covers none
  function automatic logic [7:0] covered(logic [2:0] n, logic bottom, logic [7:0] s);
    int cnt;
    cnt = (n == 3'h0) ? 0 : (256 >> (7 - n));
    return bottom ? 8'(int'(s) < cnt) : 8'(int'(s) >= 256 - cnt);
  endfunction

  task automatic wr(input logic [7:0] cmd, input logic [23:0] a, input int na,
                    input logic [15:0] d, input int nw);
    busy_len = 0;
    u_host.frame(cmd, a, na, d, nw, rd);
  endtask

  task automatic sr2(input logic [7:0] exp);
    u_host.frame(CMD_READ_STATUS_TWO, 24'h000000, 0, 16'h0000, 0, rd);
    check(rd, exp, "status2 via 07h");
  endtask

  task automatic pulse_soft();
    soft_reset = 1'b1;
    @(negedge clk_sys);
    soft_reset = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask

  initial begin
    seed = 32'h00002A52;
    {rst, ce} = 2'h3;
    {soft_reset, qpi_volatile, qpi_nv_program, uniform_sectors} = 4'h0;
    sector = 8'h00;
    core = '0;
    num_errors = 0;
    n_checks = 0;
    cycles = 0;
    busy_len = 0;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(prot, pk(3'h0, 1'b0, 1'b0, 1'b0, 1'b0), "prot after reset");
    check({6'h00, so_oe, write_busy}, 8'h00, "idle outputs");
    // suspend flags shown live, through both read commands
    for (int k = 0; k < 4; k++) begin
      {core.erase_suspended, core.program_suspended} = 2'(k);
      sr2({6'h00, 2'(k)});
      u_host.frame(CMD_READ_ANY, ADDR_SUSPEND_AND_ERASE_OUTCOME_STATUS, 3, 16'h0000, 0, rd);
      check(rd, {6'h00, 2'(k)}, "status2 via 65h");
    end
    // erase outcome taken only outside suspend; host reads right after loading
    {core.erase_suspended, core.program_suspended, core.erase_outcome} = 3'h1;
    core.erase_outcome_load = 1'b1;
    @(negedge clk_sys);
    core.erase_outcome_load = 1'b0;
    sr2(8'h04);
    {core.erase_suspended, core.erase_outcome} = 2'h2;
    core.erase_outcome_load = 1'b1;
    @(negedge clk_sys);
    core.erase_outcome_load = 1'b0;
    sr2(8'h06);
    core.erase_suspended = 1'b0;
    wr(CMD_WRITE_ANY, ADDR_SUSPEND_AND_ERASE_OUTCOME_STATUS, 3, 16'hFF00, 1);
    sr2(8'h04);
    pulse_soft();
    sr2(8'h00);
    // one-time bits chosen first, before any array operation
    wr(CMD_WRITE_REGISTERS, 24'h000000, 0, 16'h1426, 2);
    check(8'(busy_len >= 10), 8'h01, "slow nv write");
    check(prot, pk(3'h5, 1'b1, 1'b1, 1'b1, 1'b0), "wrr two bytes");
    uniform_sectors = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(prot, pk(3'h5, 1'b1, 1'b0, 1'b1, 1'b0), "uniform layout");
    uniform_sectors = 1'b0;
    qpi_volatile = 1'b1;
    wr(CMD_WRITE_REGISTERS, 24'h000000, 0, 16'h0000, 2);
    check(prot, pk(3'h0, 1'b1, 1'b1, 1'b1, 1'b0), "zero write");
    qpi_volatile = 1'b0;
    wr(CMD_WRITE_REGISTERS, 24'h000000, 0, 16'h0000, 2);
    check(prot, pk(3'h0, 1'b1, 1'b1, 1'b0, 1'b0), "quad cleared");
    qpi_nv_program = 1'b1;
    @(negedge clk_sys);
    qpi_nv_program = 1'b0;
    pulse_soft();
    check(prot, pk(3'h0, 1'b1, 1'b1, 1'b1, 1'b0), "quad default");
    wr(CMD_WRITE_ANY, ADDR_NONVOLATILE_PROTECTION_CONFIG, 3, 16'hD700, 1);
    u_host.frame(CMD_READ_ANY, ADDR_NONVOLATILE_PROTECTION_CONFIG, 3, 16'h0000, 0, rd);
    check(rd, 8'h26, "reserved and freeze default");
    // volatile select loads 111 into the active set on command reset
    wr(CMD_WRITE_REGISTERS, 24'h000000, 0, 16'h002E, 2);
    pulse_soft();
    check(prot, pk(3'h7, 1'b1, 1'b1, 1'b1, 1'b0), "volsel reload");
    for (int j = 0; j < 12; j++) begin
      n = 3'($random(seed));
      wr(CMD_WRITE_REGISTERS, 24'h000000, 0, {3'h0, n, 10'h000}, 1);
      check(8'(busy_len <= 2), 8'h01, "fast volatile write");
      check(prot, pk(n, 1'b1, 1'b1, 1'b1, 1'b0), "volatile bp");
      for (int s = 0; s < 4; s++) begin
        sector = (s == 0) ? 8'h00 : (s == 1) ? 8'hFF : 8'($random(seed));
        repeat (3) @(negedge clk_sys);
        check(8'(sector_protected), covered(n, 1'b1, sector), "sector guard");
      end
    end
    pulse_soft();
    check(prot, pk(3'h7, 1'b1, 1'b1, 1'b1, 1'b0), "nv bits untouched");
    // freeze locks the protect bits and survives command reset
    wr(CMD_WRITE_ANY, ADDR_VOLATILE_PROTECTION_CONFIG, 3, 16'h0300, 1);
    wr(CMD_WRITE_REGISTERS, 24'h000000, 0, 16'h0800, 1);
    check(prot, pk(3'h7, 1'b1, 1'b1, 1'b1, 1'b1), "frozen bp");
    pulse_soft();
    check(prot, pk(3'h7, 1'b1, 1'b1, 1'b1, 1'b1), "freeze kept");
    complete_run();
  end
endmodule // fsc_regs_tb_top
